// ---- rtl/cscu_pkg.sv ----
/*
 * Package for the CPU system control unit: register addresses, field
 * positions, reset values, gate keys and timing counts.
 * Assumes an 8-bit special-function register bus with 8-bit addresses.
 */
package cscu_pkg;
   // Register addresses on the special-function bus.
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_TIMER_PIN_FLAG = 8'h88;
   localparam logic [7:0] ADDR_EXT_FLAG = 8'h91;
   localparam logic [7:0] ADDR_LEVEL = 8'hb8;
   localparam logic [7:0] ADDR_POWER_DIVIDER = 8'hc4;
   localparam logic [7:0] ADDR_SINGLE_GATE = 8'hc7;
   localparam logic [7:0] ADDR_WINDOW_GATE = 8'hc9;
   localparam logic [7:0] ADDR_EXT_LEVEL = 8'hf8;
   // Registers guarded by the single-write gate.
   localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hd8;
   localparam logic [7:0] ADDR_MEMORY_CONTROL = 8'hc6;
   localparam logic [7:0] ADDR_ADDRESS_CONTROL = 8'h9d;
   // Registers guarded by the window gate.
   localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8f;
   localparam logic [7:0] ADDR_WAKEUP_MASK = 8'h9f;
   // Gate unlock keys and close key.
   localparam logic [7:0] KEY_FIRST = 8'haa;
   localparam logic [7:0] KEY_SECOND = 8'h55;
   localparam logic [7:0] KEY_CLOSE = 8'h00;
   // Reset values.
   localparam logic [7:0] RST_LEVEL = 8'h00;
   localparam logic [7:0] RST_EXT_LEVEL = 8'h00;
   localparam logic [2:0] RST_POWER = 3'h0;
   localparam logic [1:0] RST_DIVIDER = 2'h1;
   // Field positions.
   localparam int BIT_TF1 = 7;
   localparam int BIT_TR1 = 6;
   localparam int BIT_TF0 = 5;
   localparam int BIT_TR0 = 4;
   localparam int BIT_PIN1 = 3;
   localparam int BIT_PIN0 = 1;
   localparam int BIT_I2C_FLAG = 0;
   localparam int BIT_SLEEP = 2;
   localparam int BIT_STOP = 1;
   localparam int BIT_IDLE = 0;
   localparam int BIT_DIV_HIGH = 7;
   localparam int BIT_DIV_LOW = 6;
   localparam int BIT_AUTO_RETURN = 5;
   // Window length in system-clock periods, and divided-clock ratio.
   localparam int WINDOW_CYCLES = 256;
   localparam int DIVIDE_RATIO = 257;
   // Number of interrupt sources with a priority bit (7 + 8).
   localparam int NUM_SOURCES = 15;
   // Gate sequence states, Gray coded.
   typedef enum logic [1:0] {
      GATE_IDLE = 2'b00,
      GATE_KEYED = 2'b01
   } cscu_gate_t;
endpackage

// ---- rtl/cscu_top.sv ----
/*
 * CPU system control unit: interrupt levels and flags, timer/pin flags,
 * the single-write and window write gates, and power-mode control.
 * Assumes the CPU drives a synchronous SFR bus on MCLK and that the
 * peripheral flag inputs are already synchronous to MCLK.
 * The CPU is expected to write nothing while its clock is stopped;
 * such writes are refused here as well.
 */
//
// Contract
// - Priority bit one means high, zero low.
// - Level register bits six to zero, resets zero.
// - Extended level register eight bits, resets zero.
// - Peripheral flag bits read-only, writes ignored.
// - I2C flag sticky, cleared only by writing zero.
// - Peripheral flag bits mirror peripheral flags directly.
// - Timer flags read-only; run and pin bits writable.
// - Keys AA then 55 grant a single write.
// - Grant untimed, used once, cancelled by gate access.
// - Single gate reads unlock state in bit zero.
// - Single gate guards writes only, never reads.
// - Window keys open 256-cycle multi-write window.
// - Repeating keys restarts the window in full.
// - Writing zero closes the window at once.
// - Window status bit zero; guards clock and wake.
// - Gates freeze while the CPU clock is stopped.
// - Power control write-only, sleep stop idle bits.
// - Stop alone halts clocks; wake clears stop.
// - Sleep plus stop powers down; both clear.
// - Idle stops CPU clock, resets integrated peripherals.
// - Divider bits select full or slowed rate; DIVIDED_MODE is tied to zero here.
// - Divider high bit always reads zero.
// - High level pending served before low level.
`timescale 1ns/100ps
module cscu_top #(
   parameter int WINDOW_LEN = cscu_pkg::WINDOW_CYCLES
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RST_N,
   // SFR bus from the CPU core.
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic SFR_HIT,
   // Peripheral and timer flag inputs.
   input wire logic [6:0] PERIPH_FLAGS,
   input wire logic I2C_MASTER_SET,
   input wire logic TIMER_ZERO_OVF,
   input wire logic TIMER_ONE_OVF,
   input wire logic TIMER_ZERO_ACK,
   input wire logic TIMER_ONE_ACK,
   input wire logic PIN_ZERO_SET,
   input wire logic PIN_ONE_SET,
   // Interrupt pending vector and selected level.
   input wire logic [14:0] IRQ_PENDING,
   output logic [14:0] IRQ_LEVEL,
   output logic [14:0] IRQ_SERVE_MASK,
   // Timer run enables.
   output logic TIMER_ZERO_RUN,
   output logic TIMER_ONE_RUN,
   // Protected write permits.
   output logic SINGLE_WRITE_OK,
   output logic WINDOW_WRITE_OK,
   // Power mode control.
   input wire logic WAKE_EVENT,
   output logic IDLE_MODE,
   output logic STOP_MODE,
   output logic SLEEP_MODE,
   output logic CPU_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic INTEG_PERIPH_RST,
   output logic DIVIDED_MODE,
   output logic AUTO_RETURN
);
   // Register state.
   logic [6:0] level_ff; // Primary level bits.
   logic [7:0] ext_level_ff; // Extended level bits.
   logic i2c_flag_ff; // I2C master sticky flag.
   logic tf0_ff; // Timer zero overflow.
   logic tf1_ff; // Timer one overflow.
   logic tr0_ff; // Timer zero run.
   logic tr1_ff; // Timer one run.
   logic pin0_ff; // Pin zero flag.
   logic pin1_ff; // Pin one flag.
   logic [2:0] power_ff; // Sleep, stop, idle.
   logic div_low_ff; // Divider low bit.
   logic auto_ret_ff; // Auto return control.
   cscu_pkg::cscu_gate_t single_st_ff; // Single gate sequence state.
   logic single_grant_ff; // Single write grant.
   cscu_pkg::cscu_gate_t window_st_ff; // Window gate sequence state.
   logic [8:0] window_cnt_ff; // Remaining window cycles.
   logic [7:0] rdata_ff; // Registered read data.
   logic hit_ff; // Registered address hit.
   logic [14:0] all_level; // All priority bits in source order.
   logic clk_running; // CPU clock is running.
   logic wr_single; // Write to single gate.
   logic wr_window; // Write to window gate.
   logic acc_single; // Any access to single gate.
   logic wr_single_prot; // Write to a single-gate guarded register.
   logic [7:0] nxt_rdata; // Read data of the addressed register.
   logic nxt_hit; // Address is mapped in this block.

   // Address decode used by the guarded-write strobe.
   function automatic logic is_single_prot(input logic [7:0] a);
      is_single_prot = (a == cscu_pkg::ADDR_WATCHDOG_CONTROL) ||
                       (a == cscu_pkg::ADDR_MEMORY_CONTROL) ||
                       (a == cscu_pkg::ADDR_ADDRESS_CONTROL);
   endfunction

   // Bus strobes, gated by the running CPU clock so gates freeze.
   assign clk_running = ~(power_ff[cscu_pkg::BIT_IDLE] | power_ff[cscu_pkg::BIT_STOP]);
   assign wr_single = SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_SINGLE_GATE);
   assign wr_window = SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_WINDOW_GATE);
   assign acc_single = (SFR_WR || SFR_RD) && clk_running &&
                       (SFR_ADDR == cscu_pkg::ADDR_SINGLE_GATE);
   assign wr_single_prot = SFR_WR && clk_running && is_single_prot(SFR_ADDR);
   // Every write strobe below is gated the same way, so a halted CPU can
   // change neither a register nor a gate.

   // Priority level registers.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         level_ff <= cscu_pkg::RST_LEVEL[6:0];
         ext_level_ff <= cscu_pkg::RST_EXT_LEVEL;
      end else if (SFR_WR && clk_running) begin
         if (SFR_ADDR == cscu_pkg::ADDR_LEVEL) begin
            // Bit 7 has no source, so it is dropped.
            level_ff <= SFR_WDATA[6:0];
         end
         if (SFR_ADDR == cscu_pkg::ADDR_EXT_LEVEL) begin
            // All eight extended bits are writable.
            ext_level_ff <= SFR_WDATA;
         end
      end
   end

   // One level bit per source; one means high.
   assign all_level = {ext_level_ff, level_ff};
   assign IRQ_LEVEL = all_level;

   // Serve only high-level pending sources when any exist.
   always_comb begin
      if ((IRQ_PENDING & all_level) != 15'h0000) begin
         // Some high source waits: every low one is hidden.
         IRQ_SERVE_MASK = IRQ_PENDING & all_level;
      end else begin
         // No high source waits: natural order decides.
         IRQ_SERVE_MASK = IRQ_PENDING;
      end
   end

   // I2C flag: hardware set wins over a software clear.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         i2c_flag_ff <= 1'b0;
      end else if (I2C_MASTER_SET) begin
         // A set in the same cycle as a clear wins.
         i2c_flag_ff <= 1'b1;
      end else if (SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_EXT_FLAG) &&
                   !SFR_WDATA[cscu_pkg::BIT_I2C_FLAG]) begin
         i2c_flag_ff <= 1'b0;
      end
   end

   // Timer flags set by overflow, cleared on interrupt entry only.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         tf0_ff <= 1'b0;
         tf1_ff <= 1'b0;
      end else begin
         // Overflow wins over an interrupt-entry clear.
         // Software has no write path to these flags.
         tf0_ff <= TIMER_ZERO_OVF | (tf0_ff & ~TIMER_ZERO_ACK);
         tf1_ff <= TIMER_ONE_OVF | (tf1_ff & ~TIMER_ONE_ACK);
      end
   end

   // Writable run and pin flag bits; pin set beats clear.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         tr0_ff <= 1'b0;
         tr1_ff <= 1'b0;
         pin0_ff <= 1'b0;
         pin1_ff <= 1'b0;
      end else begin
         if (SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_TIMER_PIN_FLAG)) begin
            // Run bits follow the written value.
            tr0_ff <= SFR_WDATA[cscu_pkg::BIT_TR0];
            tr1_ff <= SFR_WDATA[cscu_pkg::BIT_TR1];
            pin0_ff <= SFR_WDATA[cscu_pkg::BIT_PIN0] | PIN_ZERO_SET;
            pin1_ff <= SFR_WDATA[cscu_pkg::BIT_PIN1] | PIN_ONE_SET;
         end else begin
            // No write: pin flags only collect new sets.
            pin0_ff <= pin0_ff | PIN_ZERO_SET;
            pin1_ff <= pin1_ff | PIN_ONE_SET;
         end
      end
   end
   assign TIMER_ZERO_RUN = tr0_ff;
   assign TIMER_ONE_RUN = tr1_ff;

   // Single-write gate: keys grant, any gate access cancels.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         single_st_ff <= cscu_pkg::GATE_IDLE;
         single_grant_ff <= 1'b0;
      end else if (wr_single) begin
         // Any gate write ends an old grant; a keyed second key starts one.
         single_grant_ff <= (single_st_ff == cscu_pkg::GATE_KEYED) &&
                            (SFR_WDATA == cscu_pkg::KEY_SECOND);
         // Only the first key arms the sequence.
         single_st_ff <= (SFR_WDATA == cscu_pkg::KEY_FIRST) ? cscu_pkg::GATE_KEYED :
                                                             cscu_pkg::GATE_IDLE;
      end else if (acc_single) begin
         // A read of the gate voids the grant as well.
         single_grant_ff <= 1'b0;
         single_st_ff <= cscu_pkg::GATE_IDLE;
      end else if (wr_single_prot) begin
         // One guarded write uses the grant.
         single_grant_ff <= 1'b0;
      end
   end
   // Writes are permitted; reads are never blocked.
   assign SINGLE_WRITE_OK = single_grant_ff;

   // Window gate: keys load the full count, zero closes.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         window_st_ff <= cscu_pkg::GATE_IDLE;
         window_cnt_ff <= 9'h000;
      end else if (wr_window) begin
         window_st_ff <= (SFR_WDATA == cscu_pkg::KEY_FIRST) ? cscu_pkg::GATE_KEYED :
                                                             cscu_pkg::GATE_IDLE;
         if ((window_st_ff == cscu_pkg::GATE_KEYED) &&
             (SFR_WDATA == cscu_pkg::KEY_SECOND)) begin
            // Open, or restart, with the full length.
            window_cnt_ff <= 9'(WINDOW_LEN);
         end else if (SFR_WDATA == cscu_pkg::KEY_CLOSE) begin
            // Early close by software.
            window_cnt_ff <= 9'h000;
         end else if (window_cnt_ff != 9'h000) begin
            // Any other gate write lets the window run on.
            window_cnt_ff <= window_cnt_ff - 9'h001;
         end
      end else if (clk_running && (window_cnt_ff != 9'h000)) begin
         // Count down only while the CPU clock runs.
         window_cnt_ff <= window_cnt_ff - 9'h001;
      end
   end
   // Window guards the clock select and wake mask registers.
   assign WINDOW_WRITE_OK = (window_cnt_ff != 9'h000);

   // Power control: write sets modes, wake clears them.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         power_ff <= cscu_pkg::RST_POWER;
      end else if (WAKE_EVENT) begin
         // A wake ends idle, stop and sleep at once.
         power_ff <= 3'h0;
      end else if (SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_POWER_CONTROL)) begin
         // Only bits 2 to 0 exist; the rest are dropped.
         power_ff <= SFR_WDATA[2:0];
      end
   end
   assign STOP_MODE = power_ff[cscu_pkg::BIT_STOP] & ~power_ff[cscu_pkg::BIT_SLEEP];
   assign SLEEP_MODE = power_ff[cscu_pkg::BIT_STOP] & power_ff[cscu_pkg::BIT_SLEEP];
   assign IDLE_MODE = power_ff[cscu_pkg::BIT_IDLE] & ~power_ff[cscu_pkg::BIT_STOP];
   assign CPU_CLK_EN = clk_running;
   assign PERIPH_CLK_EN = ~power_ff[cscu_pkg::BIT_STOP];
   assign INTEG_PERIPH_RST = IDLE_MODE;

   // Divider register; high bit is hardwired zero.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         div_low_ff <= cscu_pkg::RST_DIVIDER[0];
         auto_ret_ff <= 1'b0;
      end else if (SFR_WR && clk_running && (SFR_ADDR == cscu_pkg::ADDR_POWER_DIVIDER)) begin
         // The high divider bit is not stored at all.
         div_low_ff <= SFR_WDATA[cscu_pkg::BIT_DIV_LOW];
         auto_ret_ff <= SFR_WDATA[cscu_pkg::BIT_AUTO_RETURN];
      end
   end
   assign DIVIDED_MODE = 1'b0;
   assign AUTO_RETURN = auto_ret_ff;

   // Read multiplexer; unused and write-only bits read zero.
   always_comb begin
      nxt_rdata = 8'h00;
      // Every mapped address answers with a hit.
      nxt_hit = 1'b1;
      case (SFR_ADDR)
         cscu_pkg::ADDR_LEVEL: nxt_rdata = {1'b0, level_ff};
         cscu_pkg::ADDR_EXT_LEVEL: nxt_rdata = ext_level_ff;
         // Peripheral flags mirrored live, bit 4 unused.
         cscu_pkg::ADDR_EXT_FLAG: nxt_rdata = {PERIPH_FLAGS[6:4], 1'b0,
                                               PERIPH_FLAGS[2:0], i2c_flag_ff};
         cscu_pkg::ADDR_TIMER_PIN_FLAG: nxt_rdata = {tf1_ff, tr1_ff, tf0_ff, tr0_ff,
                                                     pin1_ff, 1'b0, pin0_ff, 1'b0};
         cscu_pkg::ADDR_POWER_CONTROL: nxt_rdata = 8'h00;
         cscu_pkg::ADDR_POWER_DIVIDER: nxt_rdata = {1'b0, div_low_ff, auto_ret_ff, 5'h00};
         cscu_pkg::ADDR_SINGLE_GATE: nxt_rdata = {7'h00, single_grant_ff};
         cscu_pkg::ADDR_WINDOW_GATE: nxt_rdata = {7'h00, WINDOW_WRITE_OK};
         // Unmapped addresses read zero with no hit.
         default: nxt_hit = 1'b0;
      endcase
   end

   // Registered read data, one cycle after the read strobe.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         rdata_ff <= 8'h00;
         hit_ff <= 1'b0;
      end else if (SFR_RD) begin
         // Capture the addressed register on a read.
         rdata_ff <= nxt_rdata;
         hit_ff <= nxt_hit;
      end else begin
         // Hit lasts one cycle; data holds until the next read.
         hit_ff <= 1'b0;
      end
   end
   assign SFR_RDATA = rdata_ff;
   assign SFR_HIT = hit_ff;

   // Checks.
   single_keys_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_single && SFR_WDATA == cscu_pkg::KEY_SECOND && single_st_ff == cscu_pkg::GATE_KEYED)
      |=> SINGLE_WRITE_OK)
      else $error("single gate did not grant after keys");
   single_use_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_single_prot && !acc_single && !wr_single) |=> !SINGLE_WRITE_OK)
      else $error("single grant not consumed");
   single_cancel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (acc_single && !(SFR_WR && SFR_WDATA == cscu_pkg::KEY_SECOND)) |=> !SINGLE_WRITE_OK)
      else $error("gate access did not cancel grant");
   window_open_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_window && SFR_WDATA == cscu_pkg::KEY_SECOND && window_st_ff == cscu_pkg::GATE_KEYED)
      |=> window_cnt_ff == 9'(WINDOW_LEN))
      else $error("window not loaded with full length");
   window_close_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr_window && SFR_WDATA == cscu_pkg::KEY_CLOSE) |=> !WINDOW_WRITE_OK)
      else $error("window not closed by zero write");
   window_freeze_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (!clk_running && !WAKE_EVENT) |=> $stable(window_cnt_ff) && $stable(single_grant_ff))
      else $error("gate moved while CPU clock stopped");
   i2c_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      I2C_MASTER_SET |=> i2c_flag_ff)
      else $error("i2c flag set lost");
   wake_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      WAKE_EVENT |=> !STOP_MODE && !SLEEP_MODE && !IDLE_MODE)
      else $error("mode bits not cleared on wake");
   level_first_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      ((IRQ_PENDING & all_level) != 15'h0000) |-> ((IRQ_SERVE_MASK & ~all_level) == 15'h0000))
      else $error("low level served ahead of high");
   // Writes that arrive while the CPU clock is off change nothing.
   halt_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (SFR_WR && !clk_running && !WAKE_EVENT) |=> $stable(level_ff) && $stable(power_ff))
      else $error("write accepted while CPU clock stopped");
   // A written run bit reaches the timer enable on the next cycle.
   run_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (SFR_WR && clk_running && SFR_ADDR == cscu_pkg::ADDR_TIMER_PIN_FLAG &&
       SFR_WDATA[cscu_pkg::BIT_TR0]) |=> TIMER_ZERO_RUN)
      else $error("timer run bit not written");
   // The write-only power register always reads zero.
   power_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
      (SFR_RD && SFR_ADDR == cscu_pkg::ADDR_POWER_CONTROL) |=> SFR_RDATA == 8'h00)
      else $error("power register read not zero");
endmodule

// ---- bench/cscu_cpu_model.sv ----
/*
 * Behavioural model of the CPU core driving the special-function bus.
 * Assumes the block samples strobes on the rising edge of MCLK and
 * answers a read with registered data one cycle later.
 */
`timescale 1ns/100ps
module cscu_cpu_model (
   // Clock.
   input wire logic MCLK,
   // Bus toward the block.
   output logic [7:0] SFR_ADDR,
   output logic SFR_WR,
   output logic SFR_RD,
   output logic [7:0] SFR_WDATA,
   // Read answer.
   input wire logic [7:0] SFR_RDATA,
   input wire logic SFR_HIT
);
   // The bus rests idle with scrambled address and data.
   initial begin
      SFR_ADDR = 8'h00;
      SFR_WR = 1'b0;
      SFR_RD = 1'b0;
      SFR_WDATA = 8'hff;
   end

   // One write strobe; software clears the i2c flag and unlocks gates with it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      SFR_ADDR <= a;
      SFR_WDATA <= d;
      SFR_WR <= 1'b1;
      @(posedge MCLK);
      SFR_WR <= 1'b0;
      SFR_ADDR <= ~a;
      SFR_WDATA <= ~d;
   endtask

   // One read strobe, then data and hit taken once they have settled.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge MCLK);
      SFR_ADDR <= a;
      SFR_RD <= 1'b1;
      @(posedge MCLK);
      SFR_RD <= 1'b0;
      SFR_ADDR <= ~a;
      #1;
      d = SFR_RDATA;
      h = SFR_HIT;
   endtask
endmodule

// ---- bench/cpu_system_control_unit_bench.sv ----
/*
 * Self-checking bench for the CPU system control unit.
 * Assumes the CPU model in cscu_cpu_model and a 50 MHz MCLK.
 */
`timescale 1ns/100ps
module cpu_system_control_unit_bench;
   // Short window so the timing tests stay brief.
   localparam int WLEN = 8;
   logic MCLK = 1'b0;
   logic RST_N = 1'b0;
   logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
   logic SFR_WR, SFR_RD, SFR_HIT;
   logic [6:0] PERIPH_FLAGS = 7'h00;
   logic I2C_MASTER_SET = 1'b0, TIMER_ZERO_OVF = 1'b0, TIMER_ONE_OVF = 1'b0;
   logic TIMER_ZERO_ACK = 1'b0, TIMER_ONE_ACK = 1'b0, PIN_ZERO_SET = 1'b0;
   logic PIN_ONE_SET = 1'b0, WAKE_EVENT = 1'b0;
   logic [14:0] IRQ_PENDING = 15'h0000;
   logic [14:0] IRQ_LEVEL, IRQ_SERVE_MASK;
   logic TIMER_ZERO_RUN, TIMER_ONE_RUN, SINGLE_WRITE_OK, WINDOW_WRITE_OK;
   logic IDLE_MODE, STOP_MODE, SLEEP_MODE, CPU_CLK_EN, PERIPH_CLK_EN;
   logic INTEG_PERIPH_RST, DIVIDED_MODE, AUTO_RETURN;
   int n_fail = 0;
   int comparisons = 0;

   // Clock of 20 ns period.
   always #10 MCLK = ~MCLK;

   cscu_top #(.WINDOW_LEN(WLEN)) u_dut (.MCLK(MCLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
      .SFR_HIT(SFR_HIT), .PERIPH_FLAGS(PERIPH_FLAGS), .I2C_MASTER_SET(I2C_MASTER_SET),
      .TIMER_ZERO_OVF(TIMER_ZERO_OVF), .TIMER_ONE_OVF(TIMER_ONE_OVF),
      .TIMER_ZERO_ACK(TIMER_ZERO_ACK), .TIMER_ONE_ACK(TIMER_ONE_ACK),
      .PIN_ZERO_SET(PIN_ZERO_SET), .PIN_ONE_SET(PIN_ONE_SET), .IRQ_PENDING(IRQ_PENDING),
      .IRQ_LEVEL(IRQ_LEVEL), .IRQ_SERVE_MASK(IRQ_SERVE_MASK),
      .TIMER_ZERO_RUN(TIMER_ZERO_RUN), .TIMER_ONE_RUN(TIMER_ONE_RUN),
      .SINGLE_WRITE_OK(SINGLE_WRITE_OK), .WINDOW_WRITE_OK(WINDOW_WRITE_OK),
      .WAKE_EVENT(WAKE_EVENT), .IDLE_MODE(IDLE_MODE), .STOP_MODE(STOP_MODE),
      .SLEEP_MODE(SLEEP_MODE), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
      .INTEG_PERIPH_RST(INTEG_PERIPH_RST), .DIVIDED_MODE(DIVIDED_MODE),
      .AUTO_RETURN(AUTO_RETURN));

   cscu_cpu_model u_cpu (.MCLK(MCLK), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT));

   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Reads a register and checks both its data and its hit flag.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      logic [7:0] d;
      logic h;
      u_cpu.rd(a, d, h);
      chk($sformatf("read %h", a), {7'h00, exp}, {7'h00, d});
      chk($sformatf("hit %h", a), {14'h0000, hit}, {14'h0000, h});
   endtask

   // Counts the cycles for which the window stays open.
   task automatic win_len(input int exp);
      int n;
      n = 0;
      #1;
      while (WINDOW_WRITE_OK === 1'b1 && n < 100) begin
         n++;
         @(posedge MCLK);
         #1;
      end
      chk("window length", exp[14:0], n[14:0]);
   endtask

   // Reset values, write-only and unused bits, unmapped address.
   task automatic t_reset();
      rchk(8'h87, 8'h00, 1'b1);
      rchk(8'h88, 8'h00, 1'b1);
      rchk(8'h91, 8'h00, 1'b1);
      rchk(8'hb8, 8'h00, 1'b1);
      rchk(8'hc4, 8'h40, 1'b1);
      rchk(8'hf8, 8'h00, 1'b1);
      rchk(8'h55, 8'h00, 1'b0);
   endtask

   // Level registers and high-before-low service.
   task automatic t_levels();
      u_cpu.wr(8'hb8, 8'hff);
      u_cpu.wr(8'hf8, 8'ha5);
      rchk(8'hb8, 8'h7f, 1'b1);
      rchk(8'hf8, 8'ha5, 1'b1);
      chk("level", {8'ha5, 7'h7f}, IRQ_LEVEL);
      @(posedge MCLK);
      IRQ_PENDING <= 15'h0180;
      @(posedge MCLK);
      #1;
      chk("serve mixed", 15'h0080, IRQ_SERVE_MASK);
      @(posedge MCLK);
      IRQ_PENDING <= 15'h0100;
      #1;
      chk("serve low", 15'h0100, IRQ_SERVE_MASK);
   endtask

   // Mirrored peripheral flags and the sticky i2c flag.
   task automatic t_flags();
      @(posedge MCLK);
      PERIPH_FLAGS <= 7'h77;
      I2C_MASTER_SET <= 1'b1;
      @(posedge MCLK);
      I2C_MASTER_SET <= 1'b0;
      u_cpu.wr(8'h91, 8'hff);
      rchk(8'h91, 8'hef, 1'b1);
      u_cpu.wr(8'h91, 8'h00);
      rchk(8'h91, 8'hee, 1'b1);
      @(posedge MCLK);
      PERIPH_FLAGS <= 7'h00;
      rchk(8'h91, 8'h00, 1'b1);
   endtask

   // Timer overflow, run and pin flags.
   task automatic t_timer();
      u_cpu.wr(8'h88, 8'hff);
      rchk(8'h88, 8'h5a, 1'b1);
      chk("runs", 15'h0003, {13'h0000, TIMER_ONE_RUN, TIMER_ZERO_RUN});
      @(posedge MCLK);
      TIMER_ZERO_OVF <= 1'b1;
      TIMER_ONE_OVF <= 1'b1;
      @(posedge MCLK);
      TIMER_ZERO_OVF <= 1'b0;
      TIMER_ONE_OVF <= 1'b0;
      rchk(8'h88, 8'hfa, 1'b1);
      @(posedge MCLK);
      TIMER_ZERO_ACK <= 1'b1;
      TIMER_ONE_ACK <= 1'b1;
      @(posedge MCLK);
      TIMER_ZERO_ACK <= 1'b0;
      TIMER_ONE_ACK <= 1'b0;
      u_cpu.wr(8'h88, 8'h00);
      rchk(8'h88, 8'h00, 1'b1);
      @(posedge MCLK);
      PIN_ZERO_SET <= 1'b1;
      PIN_ONE_SET <= 1'b1;
      @(posedge MCLK);
      PIN_ZERO_SET <= 1'b0;
      PIN_ONE_SET <= 1'b0;
      rchk(8'h88, 8'h0a, 1'b1);
   endtask

   // Single-write grant: untimed, read-transparent, used once, cancelled by a read.
   task automatic t_single();
      u_cpu.wr(8'hc7, 8'haa);
      u_cpu.wr(8'hc7, 8'h55);
      repeat (300) @(posedge MCLK);
      rchk(8'hc6, 8'h00, 1'b0);
      chk("grant held", 15'h0001, {14'h0000, SINGLE_WRITE_OK});
      u_cpu.wr(8'hc6, 8'h01);
      #1;
      chk("grant used", 15'h0000, {14'h0000, SINGLE_WRITE_OK});
      u_cpu.wr(8'hc7, 8'haa);
      u_cpu.wr(8'hc7, 8'h55);
      rchk(8'hc7, 8'h01, 1'b1);
      chk("grant void", 15'h0000, {14'h0000, SINGLE_WRITE_OK});
      rchk(8'hc7, 8'h00, 1'b1);
   endtask

   // Window length, restart, status read and early close.
   task automatic t_window();
      u_cpu.wr(8'hc9, 8'haa);
      u_cpu.wr(8'hc9, 8'h55);
      win_len(WLEN);
      u_cpu.wr(8'hc9, 8'haa);
      u_cpu.wr(8'hc9, 8'h55);
      repeat (2) @(posedge MCLK);
      u_cpu.wr(8'hc9, 8'haa);
      u_cpu.wr(8'hc9, 8'h55);
      win_len(WLEN);
      u_cpu.wr(8'hc9, 8'haa);
      u_cpu.wr(8'hc9, 8'h55);
      rchk(8'hc9, 8'h01, 1'b1);
      u_cpu.wr(8'hc9, 8'h00);
      #1;
      chk("window closed", 15'h0000, {14'h0000, WINDOW_WRITE_OK});
      rchk(8'hc9, 8'h00, 1'b1);
   endtask

   // Each power mode, refusal of writes while halted, frozen window, wake-up.
   task automatic t_power();
      logic [7:0] modes [3];
      logic [4:0] outs [3];
      modes = '{8'h01, 8'h02, 8'h06};
      outs = '{5'b10001, 5'b01000, 5'b00100};
      for (int i = 0; i < 3; i++) begin
         u_cpu.wr(8'hc9, 8'haa);
         u_cpu.wr(8'hc9, 8'h55);
         u_cpu.wr(8'h87, modes[i]);
         u_cpu.wr(8'hb8, 8'h00);
         repeat (20) @(posedge MCLK);
         #1;
         chk("mode", {10'h000, outs[i]},
            {10'h000, IDLE_MODE, STOP_MODE, SLEEP_MODE, CPU_CLK_EN, PERIPH_CLK_EN});
         chk("integ reset", {14'h0000, outs[i][4]}, {14'h0000, INTEG_PERIPH_RST});
         chk("window frozen", 15'h0001, {14'h0000, WINDOW_WRITE_OK});
         @(posedge MCLK);
         WAKE_EVENT <= 1'b1;
         @(posedge MCLK);
         WAKE_EVENT <= 1'b0;
         @(posedge MCLK);
         #1;
         chk("awake", 15'h0003,
            {10'h000, IDLE_MODE, STOP_MODE, SLEEP_MODE, CPU_CLK_EN, PERIPH_CLK_EN});
         rchk(8'hb8, 8'h7f, 1'b1);
      end
      u_cpu.wr(8'hc9, 8'h00);
      u_cpu.wr(8'hc4, 8'hff);
      rchk(8'hc4, 8'h60, 1'b1);
      chk("divided", 15'h0001, {13'h0000, DIVIDED_MODE, AUTO_RETURN});
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence after an eight-cycle reset.
   initial begin
      repeat (8) @(posedge MCLK);
      RST_N <= 1'b1;
      t_reset();
      t_levels();
      t_flags();
      t_timer();
      t_single();
      t_window();
      t_power();
      end_sim();
   end

   // Watchdog well beyond the expected run of about five hundred cycles.
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
endmodule
